// ### core/sxcar_regs.svh
// register map, field positions and timing counts of the register slice
`ifndef SXCAR_REGS_SVH
`define SXCAR_REGS_SVH
// register byte offsets
`define SXCAR_CMD_OFS 12'h2a0
`define SXCAR_RDD_OFS 12'h2a4
`define SXCAR_LOCK_OFS 12'h2a8
`define SXCAR_AUD_CTL_OFS 12'h300
`define SXCAR_INFO_OFS 12'h304
`define SXCAR_AUD_M_OFS 12'h324
`define SXCAR_AUD_N_OFS 12'h328
// command register fields
`define SXCAR_CMD_ADDR_LSB 0
`define SXCAR_CMD_WR_BIT 15
`define SXCAR_CMD_DATA_LSB 16
`define SXCAR_CMD_RESET 32'h0000_0000
// writable command bits; 14:8 are reserved and always read zero
`define SXCAR_CMD_MASK 32'hffff_80ff
// status and control fields
`define SXCAR_LOCK_BIT 0
`define SXCAR_AUD_EN_BIT 0
`define SXCAR_AUD_EN_RESET 1'b0
// info frame layout
`define SXCAR_INFO_WORDS 8
`define SXCAR_INFO_HDR_BYTES 5'h04
`define SXCAR_INFO_LAST_DB 5'h1c
`define SXCAR_INFO_DB_SHIFT 5'h03
// transceiver channels fed by each access
`define SXCAR_CHANNELS 4
// host wait after a command, in bus clocks
`define SXCAR_HOST_WAIT_CYCLES 10
`endif

// ### core/sxcar_pkg.sv
// shared types of the register slice
`default_nettype none
package sxcar_pkg;
  typedef logic [7:0] sxcar_cfg_addr_type;  // config port address
  typedef logic [15:0] sxcar_cfg_data_type; // config port data word
  typedef logic [11:0] sxcar_reg_addr_type; // register byte address
  typedef logic [31:0] sxcar_word_type;     // register data word
  // sequencer states of the config port
  typedef enum logic [1:0] {
    CFG_IDLE,
    CFG_ISSUE,
    CFG_WAIT
  } sxcar_cfg_state_type;
endpackage
`default_nettype wire

// ### core/sxcar_info_mem.sv
// info frame store: eight words, byte-lane writes, registered read
`default_nettype none
`include "sxcar_regs.svh"
module sxcar_info_mem (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] wr_lane,
  input wire logic [2:0] wr_idx,
  input wire logic [7:0] wr_byte,
  input wire logic [2:0] rd_idx,
  output logic [31:0] rd_word
);
  //////////////////////////////////////////////////////////////////////
  // one small array per byte lane, so no two processes share a variable
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      logic [7:0] store [`SXCAR_INFO_WORDS]; // lane bytes
      logic [7:0] q;                          // registered read byte
      // cleared at reset so an early read shows zeros, not unknowns
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          for (int i = 0; i < `SXCAR_INFO_WORDS; i++) begin
            store[i] <= 8'h00;
          end
          q <= 8'h00;
        end else begin
          if (wr_lane[lane]) begin
            store[wr_idx] <= wr_byte;
          end
          q <= store[rd_idx];
        end
      end
      assign rd_word[lane*8 +: 8] = q;
    end
  endgenerate
endmodule
`default_nettype wire

// ### core/sxcar_cfg_port.sv
// transceiver config port sequencer, one access broadcast to all channels
`default_nettype none
`include "sxcar_regs.svh"
module sxcar_cfg_port (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic wr_sel,
  input wire sxcar_pkg::sxcar_cfg_addr_type addr,
  input wire sxcar_pkg::sxcar_cfg_data_type wdata,
  output logic busy,
  output sxcar_pkg::sxcar_cfg_data_type rd_result,
  output logic [`SXCAR_CHANNELS-1:0] cfg_en,
  output logic cfg_we,
  output sxcar_pkg::sxcar_cfg_addr_type cfg_addr,
  output sxcar_pkg::sxcar_cfg_data_type cfg_di,
  input wire logic [`SXCAR_CHANNELS-1:0] cfg_rdy,
  input wire sxcar_pkg::sxcar_cfg_data_type cfg_do
);
  import sxcar_pkg::*;

  sxcar_cfg_state_type state, next_state; // sequencer state
  logic [`SXCAR_CHANNELS-1:0] seen, next_seen; // channels that answered
  logic next_cfg_we;
  sxcar_cfg_addr_type next_cfg_addr;
  sxcar_cfg_data_type next_cfg_di, next_rd_result;

  //////////////////////////////////////////////////////////////////////
  // next state: launch, then wait for every channel's ready
  always_comb begin
    next_state = state;
    next_seen = seen;
    next_cfg_we = cfg_we;
    next_cfg_addr = cfg_addr;
    next_cfg_di = cfg_di;
    next_rd_result = rd_result;
    case (state)
      CFG_IDLE: begin
        if (start) begin
          next_state = CFG_ISSUE;
          next_seen = '0;
          next_cfg_we = wr_sel;
          next_cfg_addr = addr;
          next_cfg_di = wdata;
        end
      end
      CFG_ISSUE, CFG_WAIT: begin
        next_state = CFG_WAIT;
        next_seen = seen | cfg_rdy;
        // only channel 0 is read back: all channels hold the same setup
        if (cfg_rdy[0] && !cfg_we) begin
          next_rd_result = cfg_do;
        end
        // no timeout: a channel that never answers holds the lock
        if (&next_seen) begin
          next_state = CFG_IDLE;
        end
      end
      default: next_state = CFG_IDLE;
    endcase
  end

  // register the sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= CFG_IDLE;
      seen <= '0;
      cfg_we <= 1'b0;
      cfg_addr <= 8'h00;
      cfg_di <= 16'h0000;
      rd_result <= 16'h0000;
    end else begin
      state <= next_state;
      seen <= next_seen;
      cfg_we <= next_cfg_we;
      cfg_addr <= next_cfg_addr;
      cfg_di <= next_cfg_di;
      rd_result <= next_rd_result;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // one enable per channel, all driven by the same launch cycle
  genvar ch;
  generate
    for (ch = 0; ch < `SXCAR_CHANNELS; ch++) begin : g_en
      assign cfg_en[ch] = (state == CFG_ISSUE);
    end
  endgenerate
  assign busy = (state != CFG_IDLE);

  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_bcast;
    (cfg_en != '0) |-> (&cfg_en) ##1 (cfg_en == '0);
  endproperty
  a_bcast: assert property (p_bcast)
    else $error("config enable not identical on all channels");

  property p_rd_capture;
    busy && !cfg_we && cfg_rdy[0] |=> rd_result == $past(cfg_do);
  endproperty
  a_rd_capture: assert property (p_rd_capture)
    else $error("read result not captured on ready");
endmodule
`default_nettype wire

// ### core/sxcar_regs.sv
// register slice: transceiver config command path and audio receive regs
`default_nettype none
`include "sxcar_regs.svh"
module sxcar_regs (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire sxcar_pkg::sxcar_reg_addr_type reg_addr,
  input wire sxcar_pkg::sxcar_word_type reg_wdata,
  output sxcar_pkg::sxcar_word_type reg_rdata,
  output logic reg_rd_valid,
  input wire logic core_cfg_busy,
  output logic [`SXCAR_CHANNELS-1:0] cfg_en,
  output logic cfg_we,
  output sxcar_pkg::sxcar_cfg_addr_type cfg_addr,
  output sxcar_pkg::sxcar_cfg_data_type cfg_di,
  input wire logic [`SXCAR_CHANNELS-1:0] cfg_rdy,
  input wire sxcar_pkg::sxcar_cfg_data_type cfg_do,
  input wire logic aud_byte_wr,
  input wire logic aud_byte_hdr,
  input wire logic [4:0] aud_byte_num,
  input wire logic [7:0] aud_byte,
  input wire logic aud_ts_valid,
  input wire logic [23:0] aud_m_in,
  input wire logic [23:0] aud_n_in,
  output logic aud_enable
);
  import sxcar_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // decoding helpers

  // address compare, used by both write and read decode
  function automatic logic hit(
    input sxcar_reg_addr_type a,
    input sxcar_reg_addr_type ofs
  );
    return a == ofs;
  endfunction

  // frame byte to store slot: {ok, slot}; slot 0-3 header, 4-31 payload
  function automatic logic [5:0] info_slot(
    input logic hdr,
    input logic [4:0] num
  );
    logic [5:0] r;
    r = 6'h00;
    if (hdr) begin
      if (num < `SXCAR_INFO_HDR_BYTES) begin
        r = {1'b1, num};
      end
    end else if (num != 5'h00 && num <= `SXCAR_INFO_LAST_DB) begin
      // incoming payload numbering starts at one, store starts at zero
      r = {1'b1, num + `SXCAR_INFO_DB_SHIFT};
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // write and read strobes
  logic cmd_wr;     // host writes the command register
  logic ctl_wr;     // host writes the audio control register
  logic info_rd;    // host reads the info frame window

  assign cmd_wr = reg_wr && hit(reg_addr, `SXCAR_CMD_OFS);
  assign ctl_wr = reg_wr && hit(reg_addr, `SXCAR_AUD_CTL_OFS);
  assign info_rd = reg_rd && hit(reg_addr, `SXCAR_INFO_OFS);

  //////////////////////////////////////////////////////////////////////
  // config command register and launch
  sxcar_word_type cmd, next_cmd;  // last written command
  logic pending, next_pending;    // command waiting for the port
  logic launch;                   // one-cycle start to the sequencer
  logic cfg_busy;                 // sequencer owns the port
  logic lock;                     // port lock flag shown to host
  sxcar_cfg_addr_type cmd_addr;   // command address field
  logic cmd_wr_sel;               // command access type
  sxcar_cfg_data_type cmd_data;   // command write data field
  sxcar_cfg_data_type rd_result;  // last port read result

  assign cmd_addr = cmd[`SXCAR_CMD_ADDR_LSB +: 8];
  assign cmd_wr_sel = cmd[`SXCAR_CMD_WR_BIT];
  // data field always goes out; a read access simply ignores it
  assign cmd_data = cmd[`SXCAR_CMD_DATA_LSB +: 16];

  // waits while the core's own logic holds the port, never collides
  assign launch = pending && !cfg_busy && !core_cfg_busy;
  assign lock = core_cfg_busy || cfg_busy || pending;

  // next command state: a fresh write wins over the launch clear
  always_comb begin
    next_cmd = cmd;
    next_pending = pending;
    if (launch) begin
      next_pending = 1'b0;
    end
    if (cmd_wr) begin
      // reserved bits are dropped on entry, so a read returns zero there
      next_cmd = reg_wdata & `SXCAR_CMD_MASK;
      next_pending = 1'b1;
    end
  end

  // register the command state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd <= `SXCAR_CMD_RESET;
      pending <= 1'b0;
    end else begin
      cmd <= next_cmd;
      pending <= next_pending;
    end
  end

  // port sequencer, broadcasts to every channel
  sxcar_cfg_port u_cfg_port (
    .clk(clk),
    .rst_b(rst_b),
    .start(launch),
    .wr_sel(cmd_wr_sel),
    .addr(cmd_addr),
    .wdata(cmd_data),
    .busy(cfg_busy),
    .rd_result(rd_result),
    .cfg_en(cfg_en),
    .cfg_we(cfg_we),
    .cfg_addr(cfg_addr),
    .cfg_di(cfg_di),
    .cfg_rdy(cfg_rdy),
    .cfg_do(cfg_do)
  );

  //////////////////////////////////////////////////////////////////////
  // audio control, time stamp values and info frame pointer
  logic next_aud_enable;
  logic [23:0] aud_m, next_aud_m;   // decoded audio M value
  logic [23:0] aud_n, next_aud_n;   // decoded audio N value
  logic [2:0] info_ptr, next_info_ptr; // keyhole read index

  // next audio state; packets are dropped while disabled
  always_comb begin
    next_aud_enable = aud_enable;
    next_aud_m = aud_m;
    next_aud_n = aud_n;
    next_info_ptr = info_ptr;
    if (ctl_wr) begin
      next_aud_enable = reg_wdata[`SXCAR_AUD_EN_BIT];
      // rewinding here lets software resync a half-read frame
      next_info_ptr = 3'h0;
    end else if (info_rd) begin
      // eight reads walk the whole frame and wrap to word zero
      next_info_ptr = info_ptr + 3'h1;
    end
    if (aud_enable && aud_ts_valid) begin
      next_aud_m = aud_m_in;
      next_aud_n = aud_n_in;
    end
  end

  // register the audio state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aud_enable <= `SXCAR_AUD_EN_RESET;
      aud_m <= 24'h000000;
      aud_n <= 24'h000000;
      info_ptr <= 3'h0;
    end else begin
      aud_enable <= next_aud_enable;
      aud_m <= next_aud_m;
      aud_n <= next_aud_n;
      info_ptr <= next_info_ptr;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // info frame byte placement
  logic [5:0] slot;       // {ok, store slot} of the incoming byte
  logic [3:0] wr_lane;    // byte lane write enables
  logic [2:0] wr_idx;     // word index of the incoming byte
  sxcar_word_type info_word; // registered word at the read pointer

  assign slot = info_slot(aud_byte_hdr, aud_byte_num);
  assign wr_idx = slot[4:2];

  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_wr_lane
      // lowest byte number lands in the lowest lane
      assign wr_lane[lane] = aud_enable && aud_byte_wr && slot[5]
        && (slot[1:0] == 2'(lane));
    end
  endgenerate

  // frame store, read at the keyhole pointer
  sxcar_info_mem u_info_mem (
    .clk(clk),
    .rst_b(rst_b),
    .wr_lane(wr_lane),
    .wr_idx(wr_idx),
    .wr_byte(aud_byte),
    .rd_idx(info_ptr),
    .rd_word(info_word)
  );

  //////////////////////////////////////////////////////////////////////
  // read path: request, one stage, then registered data
  logic rd_p1, next_rd_p1;               // read request in flight
  sxcar_reg_addr_type rd_addr_p1;        // its address
  sxcar_reg_addr_type next_rd_addr_p1;
  sxcar_word_type next_reg_rdata;
  logic next_reg_rd_valid;

  // next read state; the extra stage lets the store's registered
  // word for the old pointer arrive before the pointer moves on
  always_comb begin
    next_rd_p1 = reg_rd;
    next_rd_addr_p1 = reg_rd ? reg_addr : rd_addr_p1;
    next_reg_rd_valid = rd_p1;
    next_reg_rdata = reg_rdata;
    if (rd_p1) begin
      case (rd_addr_p1)
        `SXCAR_CMD_OFS: next_reg_rdata = cmd;
        `SXCAR_RDD_OFS: next_reg_rdata = {16'h0000, rd_result};
        `SXCAR_LOCK_OFS: next_reg_rdata = {31'h0, lock};
        `SXCAR_AUD_CTL_OFS: next_reg_rdata = {31'h0, aud_enable};
        `SXCAR_INFO_OFS: next_reg_rdata = info_word;
        `SXCAR_AUD_M_OFS: next_reg_rdata = {8'h00, aud_m};
        `SXCAR_AUD_N_OFS: next_reg_rdata = {8'h00, aud_n};
        // unmapped and unaligned addresses read as zero
        default: next_reg_rdata = 32'h0000_0000;
      endcase
    end
  end

  // register the read path
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_p1 <= 1'b0;
      rd_addr_p1 <= 12'h000;
      reg_rd_valid <= 1'b0;
      reg_rdata <= 32'h0000_0000;
    end else begin
      rd_p1 <= next_rd_p1;
      rd_addr_p1 <= next_rd_addr_p1;
      reg_rd_valid <= next_reg_rd_valid;
      reg_rdata <= next_reg_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_cfg_addr;
    launch |=> cfg_en[0] && cfg_addr == $past(cmd_addr);
  endproperty
  a_cfg_addr: assert property (p_cfg_addr)
    else $error("config address not taken from command");

  property p_cfg_we;
    launch |=> cfg_we == $past(cmd_wr_sel);
  endproperty
  a_cfg_we: assert property (p_cfg_we)
    else $error("access type does not follow command bit");

  property p_cfg_di;
    launch && cmd_wr_sel |=> cfg_we && cfg_di == $past(cmd_data);
  endproperty
  a_cfg_di: assert property (p_cfg_di)
    else $error("write data not taken from command");

  property p_lock;
    reg_rd && hit(reg_addr, `SXCAR_LOCK_OFS) ##1 core_cfg_busy
      |=> reg_rd_valid && reg_rdata[0];
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock bit clear while core uses port");

  property p_aud_gate;
    !aud_enable && aud_ts_valid |=> $stable(aud_m) && $stable(aud_n);
  endproperty
  a_aud_gate: assert property (p_aud_gate)
    else $error("time stamp taken while audio disabled");

  property p_hdr_place;
    aud_enable && aud_byte_wr && aud_byte_hdr && aud_byte_num == 5'h03
      |-> wr_lane == 4'h8 && wr_idx == 3'h0;
  endproperty
  a_hdr_place: assert property (p_hdr_place)
    else $error("header byte three misplaced");

  property p_pay_place;
    aud_enable && aud_byte_wr && !aud_byte_hdr && aud_byte_num == 5'h01
      |-> wr_lane == 4'h1 && wr_idx == 3'h1;
  endproperty
  a_pay_place: assert property (p_pay_place)
    else $error("first payload byte misplaced");

  property p_m;
    aud_enable && aud_ts_valid |=> aud_m == $past(aud_m_in);
  endproperty
  a_m: assert property (p_m)
    else $error("audio M value not captured");

  property p_n_read;
    reg_rd && hit(reg_addr, `SXCAR_AUD_N_OFS) ##1 1'b1
      |=> reg_rd_valid && reg_rdata == {8'h00, $past(aud_n)};
  endproperty
  a_n_read: assert property (p_n_read)
    else $error("audio N read back wrong or upper bits set");

  property p_one_shot;
    launch |=> cfg_en[0] ##1 !cfg_en[0] && !launch;
  endproperty
  a_one_shot: assert property (p_one_shot)
    else $error("more than one port access per command");

  c_cfg_write: cover property (launch && cmd_wr_sel ##1 cfg_en[0]);
  c_cfg_read: cover property (cfg_busy && !cfg_we && cfg_rdy[0]);
  c_info_wrap: cover property (info_rd && info_ptr == 3'h7);
  c_ts_take: cover property (aud_enable && aud_ts_valid);
endmodule
`default_nettype wire

// ### dv/sxcar_xcvr_model.sv
// behavioural model of the four transceiver config port channels
`default_nettype none
`include "sxcar_regs.svh"
module sxcar_xcvr_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] dly,
  input wire logic [`SXCAR_CHANNELS-1:0] cfg_en,
  input wire logic cfg_we,
  input wire sxcar_pkg::sxcar_cfg_addr_type cfg_addr,
  input wire sxcar_pkg::sxcar_cfg_data_type cfg_di,
  output logic [`SXCAR_CHANNELS-1:0] cfg_rdy,
  output sxcar_pkg::sxcar_cfg_data_type cfg_do
);
  timeunit 1ns;
  timeprecision 1ps;
  import sxcar_pkg::*;
  sxcar_cfg_data_type mem [`SXCAR_CHANNELS][256]; // per channel config space
  sxcar_cfg_addr_type lat [`SXCAR_CHANNELS]; // address of access in flight
  logic [4:0] cnt [`SXCAR_CHANNELS]; // cycles left to ready, 0 when idle
  ////////////////////////////////////////////////////////////////////////////
  // each channel answers later than the one before, so the sequencer
  // has to wait for the slowest one, not just channel 0
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_rdy <= '0;
      cfg_do <= 16'h0000;
      for (int c = 0; c < `SXCAR_CHANNELS; c++) begin
        cnt[c] <= 5'h00;
      end
    end else begin
      for (int c = 0; c < `SXCAR_CHANNELS; c++) begin
        cfg_rdy[c] <= (cnt[c] == 5'h01);
        if (cnt[c] != 5'h00) begin
          cnt[c] <= cnt[c] - 5'h01;
        end
        if (cfg_en[c]) begin
          cnt[c] <= 5'(dly) + 5'(c);
          lat[c] <= cfg_addr;
          if (cfg_we) begin
            mem[c][cfg_addr] <= cfg_di;
          end
        end
      end
      // data is only good with ready; toggling hides stale values
      if (cnt[0] == 5'h01) begin
        cfg_do <= mem[0][lat[0]];
      end else begin
        cfg_do <= ~cfg_do;
      end
    end
  end
endmodule
`default_nettype wire

// ### dv/sxcar_regs_tb_top.sv
// self-checking bench of the config command and audio register slice
`default_nettype none
`include "sxcar_regs.svh"
module sxcar_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sxcar_pkg::*;
  localparam sxcar_reg_addr_type OFS [8] = '{`SXCAR_CMD_OFS, `SXCAR_RDD_OFS,
    `SXCAR_LOCK_OFS, `SXCAR_AUD_CTL_OFS, `SXCAR_INFO_OFS, `SXCAR_AUD_M_OFS,
    `SXCAR_AUD_N_OFS, 12'h2ac}; // last one is unmapped
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  sxcar_reg_addr_type reg_addr = 12'h000;
  sxcar_word_type reg_wdata = 32'h0000_0000;
  sxcar_word_type reg_rdata;
  logic reg_rd_valid;
  logic core_cfg_busy = 1'b0;
  logic [3:0] cfg_en;
  logic cfg_we;
  sxcar_cfg_addr_type cfg_addr;
  sxcar_cfg_data_type cfg_di;
  sxcar_cfg_data_type cfg_do;
  logic [3:0] cfg_rdy;
  logic aud_byte_wr = 1'b0;
  logic aud_byte_hdr = 1'b0;
  logic [4:0] aud_byte_num = 5'h00;
  logic [7:0] aud_byte = 8'h00;
  logic aud_ts_valid = 1'b0;
  logic [23:0] aud_m_in = 24'h000000;
  logic [23:0] aud_n_in = 24'h000000;
  logic aud_enable;
  logic [3:0] dly = 4'h1; // model answer delay
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;
  int n_launch = 0; // config port launches seen
  int exp_launch = 0;
  logic [31:0] seed = 32'd46421;
  logic [7:0] hb [4]; // header bytes sent
  logic [7:0] db [28]; // payload bytes sent, renumbered from zero
  always #2.5 clk = ~clk;
  sxcar_regs DUT (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .core_cfg_busy(core_cfg_busy),
    .cfg_en(cfg_en), .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_di(cfg_di),
    .cfg_rdy(cfg_rdy), .cfg_do(cfg_do), .aud_byte_wr(aud_byte_wr),
    .aud_byte_hdr(aud_byte_hdr), .aud_byte_num(aud_byte_num),
    .aud_byte(aud_byte), .aud_ts_valid(aud_ts_valid), .aud_m_in(aud_m_in),
    .aud_n_in(aud_n_in), .aud_enable(aud_enable));
  sxcar_xcvr_model MODEL (.clk(clk), .rst_b(rst_b), .dly(dly),
    .cfg_en(cfg_en), .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_di(cfg_di),
    .cfg_rdy(cfg_rdy), .cfg_do(cfg_do));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_of_test();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // expected keyhole word: header first, then payload four bytes a word
  function automatic logic [31:0] info_exp(input int w);
    if (w == 0) begin
      return {hb[3], hb[2], hb[1], hb[0]};
    end
    return {db[4*w-1], db[4*w-2], db[4*w-3], db[4*w-4]};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // every launch must hit all channels together
  always @(posedge clk) begin
    cycles++;
    if (rst_b && cfg_en !== 4'h0) begin
      n_launch++;
      chk({28'h0, cfg_en}, 32'hf);
    end
    if (cycles == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic wr(input sxcar_reg_addr_type a, input sxcar_word_type d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input sxcar_reg_addr_type a, output sxcar_word_type d);
    int k;
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    k = 0;
    while (reg_rd_valid !== 1'b1 && k < 4) begin
      @(negedge clk);
      k++;
    end
    chk({31'h0, reg_rd_valid}, 32'h1);
    d = reg_rdata;
  endtask
  task automatic rdchk(input sxcar_reg_addr_type a, input sxcar_word_type e);
    sxcar_word_type d;
    rd(a, d);
    chk(d, e);
  endtask
  // poll the lock bit under a bound, as software would
  task automatic wait_unlock();
    sxcar_word_type d;
    int k;
    k = 0;
    d = 32'h1;
    while (d[0] !== 1'b0 && k < 60) begin
      rd(`SXCAR_LOCK_OFS, d);
      k++;
    end
    chk({31'h0, d[0]}, 32'h0);
  endtask
  task automatic aud_b(input logic h, input logic [4:0] n, input logic [7:0] b);
    @(negedge clk);
    aud_byte_wr = 1'b1;
    aud_byte_hdr = h;
    aud_byte_num = n;
    aud_byte = b;
    @(negedge clk);
    aud_byte_wr = 1'b0;
  endtask
  task automatic aud_ts(input logic [23:0] m, input logic [23:0] n);
    @(negedge clk);
    aud_ts_valid = 1'b1;
    aud_m_in = m;
    aud_n_in = n;
    @(negedge clk);
    aud_ts_valid = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] a;
    logic [15:0] v;
    logic [23:0] m;
    logic [23:0] n;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    foreach (OFS[i]) rdchk(OFS[i], 32'h0);
    // random write then read back through the port, random model delay
    for (int i = 0; i < 6; i++) begin
      dly = 4'(1 + xs() % 6);
      a = 8'(xs());
      v = 16'(xs());
      wait_unlock();
      // random junk in the reserved bits must not read back
      wr(`SXCAR_CMD_OFS, {v, 1'b1, 7'(xs()), a});
      rdchk(`SXCAR_CMD_OFS, {v, 8'h80, a});
      wait_unlock();
      for (int c = 0; c < `SXCAR_CHANNELS; c++) begin
        chk({16'h0, MODEL.mem[c][a]}, {16'h0, v});
      end
      wr(`SXCAR_CMD_OFS, {16'(xs()), 8'h00, a});
      repeat (10) @(negedge clk);
      wait_unlock();
      rdchk(`SXCAR_RDD_OFS, {16'h0, v});
      chk({16'h0, MODEL.mem[0][a]}, {16'h0, v});
      exp_launch += 2;
    end
    chk(n_launch, exp_launch);
    // core holds the port: commands wait, the latest one wins
    core_cfg_busy = 1'b1;
    wr(`SXCAR_CMD_OFS, {16'h1234, 8'h80, 8'h11});
    wr(`SXCAR_CMD_OFS, {16'h5678, 8'h80, 8'h22});
    repeat (20) @(negedge clk);
    rdchk(`SXCAR_LOCK_OFS, 32'h1);
    chk(n_launch, exp_launch);
    core_cfg_busy = 1'b0;
    wait_unlock();
    chk({16'h0, MODEL.mem[1][8'h22]}, 32'h5678);
    exp_launch++;
    chk(n_launch, exp_launch);
    // slow port: lock stays up while the access is in flight
    dly = 4'h8;
    wr(`SXCAR_CMD_OFS, {16'h0, 8'h00, 8'h22});
    rdchk(`SXCAR_LOCK_OFS, 32'h1);
    wait_unlock();
    rdchk(`SXCAR_RDD_OFS, 32'h5678);
    // read-only and disabled audio paths
    wr(`SXCAR_AUD_M_OFS, 32'hffff_ffff);
    rdchk(`SXCAR_AUD_M_OFS, 32'h0);
    aud_ts(24'habcdef, 24'h123456);
    rdchk(`SXCAR_AUD_M_OFS, 32'h0);
    wr(`SXCAR_AUD_CTL_OFS, 32'h1);
    rdchk(`SXCAR_AUD_CTL_OFS, 32'h1);
    chk({31'h0, aud_enable}, 32'h1);
    m = 24'(xs());
    n = 24'(xs());
    aud_ts(m, n);
    rdchk(`SXCAR_AUD_M_OFS, {8'h00, m});
    rdchk(`SXCAR_AUD_N_OFS, {8'h00, n});
    // info frame: header, payload, three out-of-range bytes that must drop
    for (int i = 0; i < 4; i++) begin
      hb[i] = 8'(xs());
      aud_b(1'b1, 5'(i), hb[i]);
    end
    for (int i = 1; i <= 28; i++) begin
      db[i-1] = 8'(xs());
      aud_b(1'b0, 5'(i), db[i-1]);
    end
    aud_b(1'b0, 5'h00, 8'hee);
    aud_b(1'b0, 5'h1d, 8'hee);
    aud_b(1'b1, 5'h04, 8'hee);
    wr(`SXCAR_AUD_CTL_OFS, 32'h1);
    for (int w = 0; w < 8; w++) begin
      rdchk(`SXCAR_INFO_OFS, info_exp(w));
    end
    rdchk(`SXCAR_INFO_OFS, info_exp(0));
    wr(`SXCAR_AUD_CTL_OFS, 32'h0);
    aud_ts(~m, ~n);
    aud_b(1'b1, 5'h00, ~hb[0]);
    rdchk(`SXCAR_AUD_M_OFS, {8'h00, m});
    rdchk(`SXCAR_INFO_OFS, info_exp(0));
    end_of_test();
  end
endmodule
`default_nettype wire
